// *** tb/pas_codec.sv ***
// Purpose: Behavioural codec on the far side of the audio port
// Assumes: Bit clock half period well above 30 ns
// Notes:   Starts each frame of bit clock and sync only while gen_i is high
`timescale 1ns/1ns

module pas_codec #(
  parameter int HALF = 244
) (
  // Board lines
  input  wire logic        bclk_i,
  input  wire logic        sync_i,
  input  wire logic        dout_i,
  // Mode and words
  input  wire logic        aux_i,
  input  wire logic        gen_i,
  input  wire logic [15:0] word_i,
  output logic             din_o = 1'b0,
  output logic             clk_o = 1'b0,
  output logic             sync_o = 1'b0,
  output logic      [15:0] rx_word_o = 16'h0
);
  logic        sq  = 1'b0;
  int          k   = -1;
  int          nrx = 16;
  logic [15:0] sh  = 16'h0;

  // Clock stands still between frames once gen_i drops
  always begin
    wait (gen_i);
    for (int i = 0; i < 256; i++) begin
      clk_o  = 1'b1;
      sync_o = (i == 0);
      #HALF clk_o = 1'b0;
      #HALF;
    end
  end

  // Sync moves in the same time step as the clock edge, so look a little after the edge
  always @(posedge bclk_i) begin
    #30;
    if (sync_i !== sq && sync_i === aux_i) begin
      k   = 15;
      nrx = 0;
    end else if (k >= 0) begin
      k = k - 1;
    end
    sq = sync_i;
    if (k >= 0)
      din_o = word_i[k];
    else
      din_o = ~din_o;
  end

  always @(negedge bclk_i) begin
    if (nrx < 16) begin
      sh  = {sh[14:0], dout_i};
      nrx = nrx + 1;
      if (nrx == 16)
        rx_word_o = sh;
    end
  end
endmodule

// *** tb/pas_top_bench.sv ***
// Purpose: Self-checking bench of the audio serial port
// Assumes: Link clock 12 ns, system clock 100 ns
// Notes:   Frame lengths and periods measured on the board lines
`timescale 1ns/1ns
`include "pas_map.svh"

module pas_top_bench;
  localparam int LK = 83333;
  logic        mclk  = 1'b0;
  logic        lclk  = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        gen   = 1'b0;
  logic        aux   = 1'b0;
  logic        sq    = 1'b0;
  logic [15:0] cw    = 16'h0;
  logic [31:0] seed  = 32'h618f9574;
  logic [63:0] per   = 64'h0;
  logic [63:0] tl    = 64'h0;
  logic [31:0] rdata;
  logic [15:0] crx;
  logic        clk_o, clk_oe, sync_o, sync_oe, dout, din, c_clk, c_sync, bclk, bsync;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  int          nfr = 0, cnt = 0, hi = 0, flen = 0, fhi = 0;

  assign bclk  = (clk_oe === 1'b1) ? clk_o : c_clk;
  assign bsync = (sync_oe === 1'b1) ? sync_o : c_sync;

  always #50 mclk = ~mclk;
  // Odd offset keeps the two clocks from ever sharing an edge
  initial begin
    #5;
    forever #6 lclk = ~lclk;
  end

  pas_top #(.LCLK_KHZ(LK)) i_pas_top (
    .mclk_i(mclk), .reset_i(reset), .lclk_i(lclk), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .pcm_clk_i(bclk), .pcm_clk_o(clk_o), .pcm_clk_oe_o(clk_oe),
    .pcm_sync_i(bsync), .pcm_sync_o(sync_o), .pcm_sync_oe_o(sync_oe),
    .pcm_din_i(din), .pcm_dout_o(dout)
  );

  pas_codec i_pas_codec (
    .bclk_i(bclk), .sync_i(bsync), .dout_i(dout), .aux_i(aux), .gen_i(gen),
    .word_i(cw), .din_o(din), .clk_o(c_clk), .sync_o(c_sync), .rx_word_o(crx)
  );

  always @(negedge bclk) begin
    if (bsync === 1'b1 && sq === 1'b0) begin
      flen <= cnt;
      fhi  <= hi;
      cnt  <= 1;
      hi   <= 1;
      nfr  <= nfr + 1;
    end else begin
      cnt <= cnt + 1;
      hi  <= hi + int'(bsync === 1'b1);
    end
    sq <= bsync;
  end

  always @(posedge bclk) begin
    per <= $time - tl;
    tl  <= $time;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task frames(input int n);
    int t;
    t = nfr + n;
    wait (nfr >= t);
  endtask

  // Fields go in with the port disabled, enable follows separately
  task cfg(input logic m, input logic a, input logic [2:0] r);
    logic [31:0] d;
    wr_reg(`PAS_CFG_OFS, {26'h0, r, a, m, 1'b0});
    wr_reg(`PAS_CFG_OFS, {26'h0, r, a, m, 1'b1});
    rd_reg(`PAS_CFG_OFS, d);
    chk(d, {26'h0, r, a, m, 1'b1});
  endtask

  task run(input logic m, input logic a, input logic [2:0] r);
    logic [31:0] d;
    logic [15:0] w;
    logic [2:0]  e;
    int          n;
    // Rates past the top, and the top rate in auxiliary, run at 2048 kHz
    e = (r > 3'h4 || (a && r == 3'h4)) ? 3'h3 : r;
    n = (e == 3'h4) ? 256 : (32 << e);
    d = xs();
    w = d[15:0];
    d = xs();
    cw  <= d[15:0];
    aux <= a;
    wr_reg(`PAS_TX_OFS, {16'h0, w});
    cfg(m, a, r);
    gen <= ~m & ~a;
    frames(3);
    chk({16'h0, crx}, {16'h0, w});
    rd_reg(`PAS_RX_OFS, d);
    chk(d, {16'h0, cw});
    rd_reg(`PAS_TX_OFS, d);
    chk(d, {16'h0, w});
    // Unread words since enable leave overrun set; next word is far off
    rd_reg(`PAS_STAT_OFS, d);
    chk(d, 32'h0000000a);
    wr_reg(`PAS_STAT_OFS, 32'h00000002);
    rd_reg(`PAS_STAT_OFS, d);
    chk(d, 32'h00000008);
    chk({30'h0, clk_oe, sync_oe}, {30'h0, m | a, m | a});
    if (m | a) begin
      chk(flen, n);
      chk(per[31:0], 24 * (LK / (512 << e)));
      chk(fhi, a ? n / 2 : 1);
    end
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    logic [31:0] d;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(`PAS_CFG_OFS, d);
    chk(d, {26'h0, `PAS_CFG_RST});
    frames(3);
    chk(flen, 256);
    chk(per[31:0], 24 * (LK / 4096));
    rd_reg(8'h10, d);
    chk(d, 32'h0);
    for (int r = 0; r < 5; r++)
      run(1'b1, 1'b0, r[2:0]);
    // Aux with a random role request must still be master
    for (int r = 0; r < 4; r++) begin
      d = xs();
      run(d[0], 1'b1, r[2:0]);
    end
    run(1'b1, 1'b1, 3'h4);
    run(1'b1, 1'b0, 3'h7);
    run(1'b0, 1'b0, 3'h3);
    end_sim();
  end
endmodule

// *** verilog/pas_link_if.sv ***
// Purpose: Bit strobes and sample words between link timing and shifter
// Assumes: All signals belong to the link clock domain
// Notes:   ctl is the timing side, eng the shift engine
`timescale 1ns/1ns
`include "pas_map.svh"

interface pas_link_if;
  logic                   rise;
  logic                   fall;
  logic                   msb;
  logic                   din;
  logic [`PAS_WORD_W-1:0] tx_word;
  logic                   dout;
  logic [`PAS_WORD_W-1:0] rx_word;
  logic                   rx_done;

  modport ctl (output rise, fall, msb, din, tx_word, input dout, rx_word, rx_done);
  modport eng (input rise, fall, msb, din, tx_word, output dout, rx_word, rx_done);
endinterface

// *** verilog/pas_map.svh ***
// Purpose: Offsets, field positions, reset values and timing of the audio port
// Assumes: Included by bare name wherever a number is needed
// Notes:   Definitions only
`ifndef PAS_MAP_SVH
`define PAS_MAP_SVH

// Register bus
`define PAS_ADDR_W        8
`define PAS_DATA_W        32
`define PAS_CFG_OFS       8'h00
`define PAS_STAT_OFS      8'h04
`define PAS_TX_OFS        8'h08
`define PAS_RX_OFS        8'h0c

// Configuration command fields
`define PAS_CFG_W         6
`define PAS_CFG_EN        0
`define PAS_CFG_MASTER    1
`define PAS_CFG_AUX       2
`define PAS_CFG_RATE_LO   3
`define PAS_CFG_RATE_HI   5
// Enabled, master, primary format, 2048 kHz bit clock
`define PAS_CFG_RST       6'h1b

// Status fields
`define PAS_ST_RXRDY      0
`define PAS_ST_OVR        1
`define PAS_ST_TXPEND     2
`define PAS_ST_ACTIVE     3

// Sample word and clock rates
`define PAS_WORD_W        16
`define PAS_FS_KHZ        8
`define PAS_FS_FAST_KHZ   16
`define PAS_BCLK_MIN_KHZ  256
`define PAS_BCLK_TOP_KHZ  4096
`define PAS_RATE_2048     3'h3
`define PAS_RATE_4096     3'h4
`define PAS_LCLK_KHZ      83333

`endif

// *** verilog/pas_pkg.sv ***
// Purpose: Types shared by the audio serial port modules
// Assumes: Nothing is imported; users write pas_pkg::name
// Notes:   Numbers live in pas_map.svh
package pas_pkg;

  typedef enum logic [0:0] {
    PAS_IDLE,
    PAS_SHIFT
  } pas_shift_st_t;

endpackage

// *** verilog/pas_shift.sv ***
// Purpose: Shifts one sample word out and one in per frame
// Assumes: rise, fall and msb are one-cycle strobes, msb only on a rise
// Notes:   Output line idles low once the word has been sent
`timescale 1ns/1ns
`include "pas_map.svh"

module pas_shift (
  // Link clock domain
  input  wire logic lclk_i,
  input  wire logic lrst_i,
  // Strobes and sample words
  pas_link_if.eng   lnk
);
  localparam logic [3:0] LAST_BIT = 4'(`PAS_WORD_W - 1);

  pas_pkg::pas_shift_st_t st;
  pas_pkg::pas_shift_st_t next_st;
  logic [`PAS_WORD_W-1:0] tx_sh;
  logic [`PAS_WORD_W-1:0] next_tx_sh;
  logic [`PAS_WORD_W-1:0] rx_sh;
  logic [`PAS_WORD_W-1:0] next_rx_sh;
  logic [`PAS_WORD_W-1:0] rx_word;
  logic [`PAS_WORD_W-1:0] next_rx_word;
  logic [3:0]             cnt;
  logic [3:0]             next_cnt;
  logic                   done;
  logic                   next_done;

  always_comb begin
    next_st      = st;
    next_tx_sh   = tx_sh;
    next_rx_sh   = rx_sh;
    next_rx_word = rx_word;
    next_cnt     = cnt;
    next_done    = 1'b0;
    if (lnk.msb) begin
      // Fresh word, top bit goes out first
      next_tx_sh = lnk.tx_word;
      next_cnt   = 4'h0;
      next_st    = pas_pkg::PAS_SHIFT;
    end else if (lnk.rise) begin
      next_tx_sh = {tx_sh[`PAS_WORD_W-2:0], 1'b0};
    end
    unique case (st)
      pas_pkg::PAS_IDLE: begin
      end
      pas_pkg::PAS_SHIFT: begin
        if (lnk.fall) begin
          next_rx_sh = {rx_sh[`PAS_WORD_W-2:0], lnk.din};
          next_cnt   = cnt + 4'h1;
          if (cnt == LAST_BIT) begin
            next_rx_word = {rx_sh[`PAS_WORD_W-2:0], lnk.din};
            next_done    = 1'b1;
            next_st      = pas_pkg::PAS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge lclk_i) begin
    if (lrst_i) begin
      st      <= pas_pkg::PAS_IDLE;
      tx_sh   <= '0;
      rx_sh   <= '0;
      rx_word <= '0;
      cnt     <= 4'h0;
      done    <= 1'b0;
    end else begin
      st      <= next_st;
      tx_sh   <= next_tx_sh;
      rx_sh   <= next_rx_sh;
      rx_word <= next_rx_word;
      cnt     <= next_cnt;
      done    <= next_done;
    end
  end

  assign lnk.dout    = tx_sh[`PAS_WORD_W-1];
  assign lnk.rx_word = rx_word;
  assign lnk.rx_done = done;

  a_msb_first: assert property (@(posedge lclk_i) disable iff (lrst_i)
    lnk.msb |=> lnk.dout == $past(lnk.tx_word[`PAS_WORD_W-1]))
    else $error("Sample did not start with its top bit");
endmodule

// *** verilog/pas_top.sv ***
// Purpose: Audio sample serial port towards a codec, with register access
// Assumes: lclk_i runs free and is many times the fastest bit clock
// Notes:   Change format or rate with the port disabled, then enable it
//
// Our own choices: strobed register access and the address map.

`timescale 1ns/1ns
`include "pas_map.svh"

module pas_top #(
  parameter int LCLK_KHZ = `PAS_LCLK_KHZ
) (
  // System clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  // Link reference clock
  input  wire logic                   lclk_i,
  // Register port
  input  wire logic [`PAS_ADDR_W-1:0] addr_i,
  input  wire logic [`PAS_DATA_W-1:0] wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [`PAS_DATA_W-1:0] rdata_o,
  // Codec link pins
  input  wire logic                   pcm_clk_i,
  output logic                        pcm_clk_o,
  output logic                        pcm_clk_oe_o,
  input  wire logic                   pcm_sync_i,
  output logic                        pcm_sync_o,
  output logic                        pcm_sync_oe_o,
  input  wire logic                   pcm_din_i,
  output logic                        pcm_dout_o
);
  localparam int WW = `PAS_WORD_W;

  pas_link_if lnk ();

  // Register side state
  logic [`PAS_CFG_W-1:0]  audio_port_config_command;
  logic [`PAS_CFG_W-1:0]  next_cfg;
  logic [WW-1:0]          tx_data;
  logic [WW-1:0]          next_tx_data;
  logic [WW-1:0]          rx_data;
  logic [WW-1:0]          next_rx_data;
  logic                   rx_rdy;
  logic                   next_rx_rdy;
  logic                   ovr;
  logic                   next_ovr;
  logic                   tx_pend;
  logic                   next_tx_pend;
  logic                   tx_tgl;
  logic                   next_tx_tgl;
  logic [`PAS_DATA_W-1:0] next_rdata;
  logic [2:0]             rx_s;
  logic [2:0]             ack_s;
  logic [1:0]             act_s;

  // Link side state
  logic                   lrst_s1;
  logic                   lrst;
  logic [`PAS_CFG_W-1:0]  cfg_s1;
  logic [`PAS_CFG_W-1:0]  cfg_s2;
  logic [`PAS_CFG_W-1:0]  lcfg;
  logic [`PAS_CFG_W-1:0]  next_lcfg;
  logic [2:0]             tx_s;
  logic [WW-1:0]          tx_hold;
  logic [WW-1:0]          next_tx_hold;
  logic                   fresh;
  logic                   next_fresh;
  logic                   ack_l;
  logic                   next_ack_l;
  logic                   rx_l;
  logic                   next_rx_l;
  logic [11:0]            div_cnt;
  logic [11:0]            next_div;
  logic [8:0]             per_cnt;
  logic [8:0]             next_per;
  logic [8:0]             nper;
  logic                   bclk_q;
  logic                   next_bclk;
  logic                   sync_q;
  logic                   next_sync;
  logic                   sync_seen;
  logic                   next_sync_seen;
  logic                   next_dout;
  logic                   next_oe;
  logic [2:0]             clk_s;
  logic [1:0]             syn_s;
  logic [1:0]             din_s;
  logic                   m_tick;
  logic                   m_rise;
  logic                   m_fall;
  logic                   s_rise;
  logic                   s_fall;
  logic                   len;
  logic                   laux;
  logic                   lmaster;
  logic [2:0]             lrate;

  // Cycles of lclk per bit clock half period, rounded down, never zero
  function automatic logic [11:0] half_cnt(input logic [2:0] r);
    int k;
    int h;
    k = (r == `PAS_RATE_4096) ? `PAS_BCLK_TOP_KHZ : (`PAS_BCLK_MIN_KHZ << r);
    h = LCLK_KHZ / (2 * k);
    return 12'((h < 1) ? 1 : h);
  endfunction

  // Bit clock periods per frame
  function automatic logic [8:0] frame_bits(input logic [2:0] r);
    if (r == `PAS_RATE_4096) begin
      return 9'(`PAS_BCLK_TOP_KHZ / `PAS_FS_FAST_KHZ);
    end
    return 9'((`PAS_BCLK_MIN_KHZ << r) / `PAS_FS_KHZ);
  endfunction

  // Register side: bus access, word handover, status
  always_comb begin
    next_cfg     = audio_port_config_command;
    next_tx_data = tx_data;
    next_rx_data = rx_data;
    next_rx_rdy  = rx_rdy;
    next_ovr     = ovr;
    next_tx_pend = tx_pend;
    next_tx_tgl  = tx_tgl;
    next_rdata   = '0;
    // Word taken by the link; a write in this cycle sets it again
    if (ack_s[2] != ack_s[1]) begin
      next_tx_pend = 1'b0;
    end
    if (wr_i) begin
      unique case (addr_i)
        `PAS_CFG_OFS: next_cfg = wdata_i[`PAS_CFG_W-1:0];
        `PAS_STAT_OFS: begin
          if (wdata_i[`PAS_ST_OVR]) begin
            next_ovr = 1'b0;
          end
        end
        `PAS_TX_OFS: begin
          next_tx_data = wdata_i[WW-1:0];
          next_tx_tgl  = ~tx_tgl;
          next_tx_pend = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `PAS_CFG_OFS:  next_rdata = {26'h0, audio_port_config_command};
        `PAS_STAT_OFS: next_rdata = {28'h0, act_s[1], tx_pend, ovr, rx_rdy};
        `PAS_TX_OFS:   next_rdata = {16'h0, tx_data};
        `PAS_RX_OFS: begin
          next_rdata  = {16'h0, rx_data};
          next_rx_rdy = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // A word arriving now wins over a read or clear in the same cycle
    if (rx_s[2] != rx_s[1]) begin
      next_rx_data = lnk.rx_word;
      next_rx_rdy  = 1'b1;
      if (rx_rdy) begin
        next_ovr = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      audio_port_config_command <= `PAS_CFG_RST;
      tx_data <= '0;
      rx_data <= '0;
      rx_rdy  <= 1'b0;
      ovr     <= 1'b0;
      tx_pend <= 1'b0;
      tx_tgl  <= 1'b0;
      rdata_o <= '0;
      rx_s    <= 3'h0;
      ack_s   <= 3'h0;
      act_s   <= 2'h0;
    end else begin
      audio_port_config_command <= next_cfg;
      tx_data <= next_tx_data;
      rx_data <= next_rx_data;
      rx_rdy  <= next_rx_rdy;
      ovr     <= next_ovr;
      tx_pend <= next_tx_pend;
      tx_tgl  <= next_tx_tgl;
      rdata_o <= next_rdata;
      rx_s    <= {rx_s[1:0], rx_l};
      ack_s   <= {ack_s[1:0], ack_l};
      act_s   <= {act_s[0], len};
    end
  end

  // Into the link domain: reset, configuration, pins
  always_ff @(posedge lclk_i) begin
    lrst_s1 <= reset_i;
    lrst    <= lrst_s1;
    cfg_s1  <= audio_port_config_command;
    cfg_s2  <= cfg_s1;
    clk_s   <= {clk_s[1:0], pcm_clk_i};
    syn_s   <= {syn_s[0], pcm_sync_i};
    din_s   <= {din_s[0], pcm_din_i};
  end

  assign len     = lcfg[`PAS_CFG_EN];
  assign laux    = lcfg[`PAS_CFG_AUX];
  // Auxiliary format forces the master role
  assign lmaster = lcfg[`PAS_CFG_MASTER] || laux;
  assign lrate   = (lcfg[`PAS_CFG_RATE_HI:`PAS_CFG_RATE_LO] > `PAS_RATE_4096 ||
                    (laux && lcfg[`PAS_CFG_RATE_HI:`PAS_CFG_RATE_LO] == `PAS_RATE_4096))
                   ? `PAS_RATE_2048 : lcfg[`PAS_CFG_RATE_HI:`PAS_CFG_RATE_LO];

  // Link side: bit clock, frame timing, word handover
  always_comb begin
    // Bits are taken only while enable is low, so skew cannot mix settings
    next_lcfg = (lcfg[`PAS_CFG_EN] && cfg_s2[`PAS_CFG_EN]) ? lcfg : cfg_s2;
    m_tick    = len && lmaster && (div_cnt == half_cnt(lrate) - 12'h001);
    m_rise    = m_tick && !bclk_q;
    m_fall    = m_tick && bclk_q;
    s_rise    = len && !lmaster && !clk_s[2] && clk_s[1];
    s_fall    = len && !lmaster && clk_s[2] && !clk_s[1];
    nper      = (per_cnt == frame_bits(lrate) - 9'h001) ? 9'h000 : per_cnt + 9'h001;
    lnk.rise  = m_rise || s_rise;
    lnk.fall  = m_fall || s_fall;
    if (m_rise) begin
      lnk.msb = laux ? (nper == 9'h000) : (nper == 9'h001);
    end else begin
      lnk.msb = s_rise && sync_seen;
    end
    lnk.din     = din_s[1];
    lnk.tx_word = tx_hold;
    next_div    = (!len || !lmaster || m_tick) ? 12'h000 : div_cnt + 12'h001;
    next_bclk   = len && lmaster && (m_tick ? !bclk_q : bclk_q);
    next_per    = !len ? frame_bits(lrate) - 9'h001 : (m_rise ? nper : per_cnt);
    if (!len) begin
      next_sync = 1'b0;
    end else if (!m_rise) begin
      next_sync = sync_q;
    end else if (laux) begin
      next_sync = nper < (frame_bits(lrate) >> 1);
    end else begin
      next_sync = nper == 9'h000;
    end
    // Slave: sync high at a falling edge puts the top bit after the next rise
    if (s_fall) begin
      next_sync_seen = syn_s[1];
    end else if (s_rise) begin
      next_sync_seen = 1'b0;
    end else begin
      next_sync_seen = sync_seen;
    end
    // A new word arriving at the frame start stays fresh for the next frame
    next_tx_hold = (tx_s[2] != tx_s[1]) ? tx_data : tx_hold;
    next_fresh   = (tx_s[2] != tx_s[1]) || (fresh && !lnk.msb);
    next_ack_l   = (lnk.msb && fresh) ? ~ack_l : ack_l;
    next_rx_l    = lnk.rx_done ? ~rx_l : rx_l;
    next_dout    = lnk.dout;
    next_oe      = lmaster;
  end

  always_ff @(posedge lclk_i) begin
    if (lrst) begin
      lcfg          <= `PAS_CFG_RST;
      tx_s          <= 3'h0;
      tx_hold       <= '0;
      fresh         <= 1'b0;
      ack_l         <= 1'b0;
      rx_l          <= 1'b0;
      div_cnt       <= 12'h000;
      per_cnt       <= 9'h000;
      bclk_q        <= 1'b0;
      sync_q        <= 1'b0;
      sync_seen     <= 1'b0;
      pcm_dout_o    <= 1'b0;
      pcm_clk_oe_o  <= 1'b1;
      pcm_sync_oe_o <= 1'b1;
    end else begin
      lcfg          <= next_lcfg;
      tx_s          <= {tx_s[1:0], tx_tgl};
      tx_hold       <= next_tx_hold;
      fresh         <= next_fresh;
      ack_l         <= next_ack_l;
      rx_l          <= next_rx_l;
      div_cnt       <= next_div;
      per_cnt       <= next_per;
      bclk_q        <= next_bclk;
      sync_q        <= next_sync;
      sync_seen     <= next_sync_seen;
      pcm_dout_o    <= next_dout;
      pcm_clk_oe_o  <= next_oe;
      pcm_sync_oe_o <= next_oe;
    end
  end

  assign pcm_clk_o  = bclk_q;
  assign pcm_sync_o = sync_q;

  pas_shift u_shift (
    .lclk_i (lclk_i),
    .lrst_i (lrst),
    .lnk    (lnk.eng)
  );

  // Checking helpers: falls since the top bit, cycles since the clock pin moved
  logic [8:0]  hc_falls;
  logic [11:0] hc_run;
  always_ff @(posedge lclk_i) begin
    if (lrst || lnk.msb) begin
      hc_falls <= 9'h000;
    end else if (lnk.fall) begin
      hc_falls <= hc_falls + 9'h001;
    end
    if (lrst || !len || pcm_clk_o != next_bclk) begin
      hc_run <= 12'h000;
    end else begin
      hc_run <= hc_run + 12'h001;
    end
  end

  a_dout_after_rise: assert property (@(posedge lclk_i) disable iff (lrst)
    $changed(pcm_dout_o) |-> $past(lnk.rise, 2))
    else $error("Data output moved away from a rising bit clock");

  a_prim_sync_fall: assert property (@(posedge lclk_i) disable iff (lrst)
    (lmaster && !laux && len && $fell(pcm_sync_o)) |-> $past(lnk.msb))
    else $error("Primary sync fell away from the top bit");

  a_aux_sync_rise: assert property (@(posedge lclk_i) disable iff (lrst)
    (laux && $rose(pcm_sync_o)) |-> $past(lnk.msb))
    else $error("Auxiliary sync rose away from the top bit");

  a_aux_half_duty: assert property (@(posedge lclk_i) disable iff (lrst)
    (laux && len && $stable(lcfg)) |-> (pcm_sync_o == (per_cnt < (frame_bits(lrate) >> 1))))
    else $error("Auxiliary sync is not high for half the frame");

  a_aux_drives: assert property (@(posedge lclk_i) disable iff (lrst)
    laux |=> (pcm_clk_oe_o && pcm_sync_oe_o))
    else $error("Auxiliary format left the link undriven");

  a_bclk_half: assert property (@(posedge lclk_i) disable iff (lrst)
    (len && lmaster && $stable(lcfg) && m_tick) |-> hc_run == half_cnt(lrate) - 12'h001)
    else $error("Bit clock half period has the wrong length");

  a_prim_pulse: assert property (@(posedge lclk_i) disable iff (lrst)
    (lmaster && !laux && len && lnk.fall) |-> pcm_sync_o == (per_cnt == 9'h000))
    else $error("Primary sync pulse is not exactly the first bit period");

  a_word_sixteen: assert property (@(posedge lclk_i) disable iff (lrst)
    lnk.rx_done |-> $past(hc_falls) == 9'(WW - 1))
    else $error("Received word was not sixteen bits");

  a_cfg_default: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> audio_port_config_command == `PAS_CFG_RST)
    else $error("Configuration is not at its default after reset");

  a_rx_set_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
    (rx_s[2] != rx_s[1]) |=> rx_rdy)
    else $error("Arriving word did not set the ready flag");
endmodule
